// [include/sfr_upper_pkg.sv]
// Constants for the upper special register bank
//
// Function
// - Writing 0 to a pending-interrupt bit clears it; writing 1 leaves it alone.
// - Writing a timer count loads it from its reload; reads return the live count.
// - Analog control bits change only when bit 7 of the written value is 0.
// - Timer three setup holds run, polarity, source, gate and 3-bit prescale fields.
// - The PWM duty is 10 bits: high eight in data, low two in setup.
// - PWM setup has ten-bit mode, 2-bit period, enable; bits 4 and 1 read zero.
// - Comparator reference holds a 4-bit value; upper four bits read zero.
// - Audio wake control has power, two thresholds, and reads detection in bit 6.
// - Port two has a sampled input register and an output register reset to zero.
// - Pending and mask registers share one bit order from multitask timer to timer 1.
package sfr_upper_pkg;

  // Register offsets
  localparam logic [7:0] AUDIO_WAKE_OFS   = 8'hce;
  localparam logic [7:0] HELD_FLAGS_OFS   = 8'hcf;
  localparam logic [7:0] SYSTEM_SETUP_OFS = 8'hd1;
  localparam logic [7:0] EXT_PAGE_OFS     = 8'hd2;
  localparam logic [7:0] CMP_REF_OFS      = 8'hd3;
  localparam logic [7:0] CMP_SETUP_OFS    = 8'hd5;
  localparam logic [7:0] CLOCK_EXT_OFS    = 8'hd6;
  localparam logic [7:0] PWM_SETUP_OFS    = 8'hd7;
  localparam logic [7:0] PWM_DUTY_OFS     = 8'hd8;
  localparam logic [7:0] T3_SETUP_OFS     = 8'hd9;
  localparam logic [7:0] T3_RELOAD_OFS    = 8'hda;
  localparam logic [7:0] T3_COUNT_OFS     = 8'hdb;
  localparam logic [7:0] P2_OUT_OFS       = 8'hdc;
  localparam logic [7:0] P2_IN_OFS        = 8'hdd;
  localparam logic [7:0] ANALOG_CTL_OFS   = 8'hef;
  localparam logic [7:0] IRQ_MASK_OFS     = 8'hfd;
  localparam logic [7:0] IRQ_PEND_OFS     = 8'hfe;

  // Writable bits of each register
  localparam logic [7:0] AUDIO_WAKE_WMASK = 8'hbf;
  localparam logic [7:0] HELD_FLAGS_WMASK = 8'hf1;
  localparam logic [7:0] SYSTEM_WMASK     = 8'hfb;
  localparam logic [7:0] EXT_PAGE_WMASK   = 8'h3f;
  localparam logic [7:0] CMP_REF_WMASK    = 8'h0f;
  localparam logic [7:0] CMP_SETUP_WMASK  = 8'h0f;
  localparam logic [7:0] CLOCK_EXT_WMASK  = 8'hf7;
  localparam logic [7:0] PWM_SETUP_WMASK  = 8'hed;
  localparam logic [7:0] T3_SETUP_WMASK   = 8'hf7;
  localparam logic [7:0] ANALOG_WMASK     = 8'h39;

  // Reset values
  localparam logic [7:0] REG_RST          = 8'h00;
  localparam logic [1:0] CMP_OUT_RST      = 2'h3;

  // Field positions
  localparam int ANALOG_LOCK_BIT   = 7;
  localparam int AWAKE_DETECT_BIT  = 6;
  localparam int T3_RUN_BIT        = 7;
  localparam int T3_POLARITY_BIT   = 6;
  localparam int T3_SOURCE_BIT     = 5;
  localparam int T3_GATE_BIT       = 4;
  localparam int T3_PS_MSB         = 2;
  localparam int PWM_LOW_MSB       = 7;
  localparam int PWM_TEN_BIT       = 5;
  localparam int PWM_CYCLE_MSB     = 3;
  localparam int PWM_ON_BIT        = 0;

  // Interrupt bit order
  localparam int IRQ_MULTITASK_BIT = 7;
  localparam int IRQ_P0_2_BIT      = 6;
  localparam int IRQ_BLOCK_BIT     = 5;
  localparam int IRQ_TIMER3_BIT    = 4;
  localparam int IRQ_P0_0_BIT      = 3;
  localparam int IRQ_ENDMARK_BIT   = 2;
  localparam int IRQ_TIMER2_BIT    = 1;
  localparam int IRQ_TIMER1_BIT    = 0;

endpackage

// [verilog/reload_timer.sv]
// Prescaled up-counter that reloads on overflow or on request
`timescale 1ns/1ps
`default_nettype none
module reload_timer #(
  parameter int WIDTH   = 8,
  parameter int PS_BITS = 3
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // Control
  input  wire logic               run_i,
  input  wire logic               gate_ok_i,
  input  wire logic [PS_BITS-1:0] prescale_i,
  input  wire logic               load_i,
  input  wire logic [WIDTH-1:0]   reload_i,
  // Status
  output logic      [WIDTH-1:0]   count_o,
  output logic                    wrap_o
);
  localparam int PRE_W = (2 ** PS_BITS) - 1;

  if (WIDTH < 2 || PS_BITS < 1 || PS_BITS > 4) begin : g_bad_params
    $error("reload_timer: unsupported WIDTH or PS_BITS");
  end

  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_mask;
  logic             tick;
  logic             counting;

  assign counting = run_i && gate_ok_i;
  assign pre_mask = ~({PRE_W{1'b1}} << prescale_i);
  assign tick     = counting && ((pre_reg & pre_mask) == pre_mask);

  // Prescaler divides the clock by two to the prescale select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        pre_reg <= '0;
      end else if (counting) begin
        pre_reg <= pre_reg + 1'b1;
      end
    end
  end

  // Count up, reload on overflow or when software writes the count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
      wrap_o  <= 1'b0;
    end else if (ce_i) begin
      wrap_o <= 1'b0;
      if (load_i) begin
        count_o <= reload_i;
      end else if (tick) begin
        if (&count_o) begin
          count_o <= reload_i;
          wrap_o  <= 1'b1;
        end else begin
          count_o <= count_o + 1'b1;
        end
      end
    end
  end
endmodule // reload_timer
`default_nettype wire

// [verilog/sfr_upper_bank.sv]
// Upper special register bank with timer three, port two and interrupts
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sfr_upper_bank
  import sfr_upper_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Interrupt events and request
  input  wire logic [7:0] event_i,
  output logic            irq_o,
  // Pins and analog status
  input  wire logic [7:0] port_two_pin_i,
  input  wire logic       comparator_a_output_i,
  input  wire logic       comparator_b_output_i,
  input  wire logic       wake_detect_i,
  input  wire logic       timer_three_gate_pin_i,
  // Register contents toward the chip
  output logic      [7:0] port_two_output_o,
  output logic      [7:0] timer_three_count_o,
  output logic      [7:0] timer_three_setup_o,
  output logic      [9:0] pwm_duty_o,
  output logic      [7:0] pwm_setup_o,
  output logic      [7:0] comparator_setup_o,
  output logic      [7:0] comparator_reference_o,
  output logic      [7:0] external_address_page_o,
  output logic      [7:0] held_flags_copy_o,
  output logic      [7:0] audio_wake_control_o,
  output logic      [7:0] clock_extension_setup_o,
  output logic      [7:0] system_setup_o,
  output logic      [7:0] analog_control_o,
  output logic      [7:0] irq_mask_o
);
  localparam int SYNC_W = 12;

  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("sfr_upper_bank: SYNC_STAGES must be 2");
  end

  localparam logic [SYNC_W-1:0] SYNC_RST = {2'b00, CMP_OUT_RST, 8'h00};

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [7:0]        pin_sync;
  logic              cmp_a_sync;
  logic              cmp_b_sync;
  logic              detect_sync;
  logic              gate_sync;
  logic [7:0]        irq_reg;
  logic [7:0]        irq_next;
  logic [7:0]        imr_reg;
  logic [7:0]        events;
  logic [7:0]        read_value;
  logic [7:0]        t3_reload_reg;
  logic [7:0]        pwm_data_reg;
  logic              wr_en;
  logic              rd_en;
  logic              t3_wrap;
  logic              t3_gate_ok;

  assign wr_en = wr_i && ce_i;
  assign rd_en = rd_i && ce_i;

  // Two-stage synchroniser for all pin and analog inputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else if (ce_i) begin
      sync1_reg <= {timer_three_gate_pin_i, wake_detect_i, comparator_a_output_i,
                    comparator_b_output_i, port_two_pin_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_sync    = sync2_reg[7:0];
  assign cmp_b_sync  = sync2_reg[8];
  assign cmp_a_sync  = sync2_reg[9];
  assign detect_sync = sync2_reg[10];
  assign gate_sync   = sync2_reg[11];

  // Plain registers with fixed-zero bits masked; all read back except timer three setup, which reads zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_two_output_o       <= REG_RST;
      t3_reload_reg           <= REG_RST;
      timer_three_setup_o     <= REG_RST;
      pwm_data_reg            <= REG_RST;
      pwm_setup_o             <= REG_RST;
      comparator_reference_o  <= REG_RST;
      external_address_page_o <= REG_RST;
      held_flags_copy_o       <= REG_RST;
      audio_wake_control_o    <= REG_RST;
      clock_extension_setup_o <= REG_RST;
      system_setup_o          <= REG_RST;
      irq_mask_o              <= REG_RST;
      imr_reg                 <= REG_RST;
    end else if (wr_en) begin
      case (addr_i)
        P2_OUT_OFS:       port_two_output_o       <= wdata_i;
        T3_RELOAD_OFS:    t3_reload_reg           <= wdata_i;
        T3_SETUP_OFS:     timer_three_setup_o     <= wdata_i & T3_SETUP_WMASK;
        PWM_DUTY_OFS:     pwm_data_reg            <= wdata_i;
        PWM_SETUP_OFS:    pwm_setup_o             <= wdata_i & PWM_SETUP_WMASK;
        CMP_REF_OFS:      comparator_reference_o  <= wdata_i & CMP_REF_WMASK;
        EXT_PAGE_OFS:     external_address_page_o <= wdata_i & EXT_PAGE_WMASK;
        HELD_FLAGS_OFS:   held_flags_copy_o       <= wdata_i & HELD_FLAGS_WMASK;
        AUDIO_WAKE_OFS:   audio_wake_control_o    <= wdata_i & AUDIO_WAKE_WMASK;
        CLOCK_EXT_OFS:    clock_extension_setup_o <= wdata_i & CLOCK_EXT_WMASK;
        SYSTEM_SETUP_OFS: system_setup_o          <= wdata_i & SYSTEM_WMASK;
        IRQ_MASK_OFS: begin
          imr_reg    <= wdata_i;
          irq_mask_o <= wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // Comparator setup keeps only mux and channel; outputs come from the comparators
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comparator_setup_o <= {CMP_OUT_RST, 6'h00};
    end else if (ce_i) begin
      comparator_setup_o[7:6] <= {cmp_a_sync, cmp_b_sync};
      comparator_setup_o[5:4] <= 2'h0;
      if (wr_i && addr_i == CMP_SETUP_OFS) begin
        comparator_setup_o[3:0] <= wdata_i[3:0] & CMP_SETUP_WMASK[3:0];
      end
    end
  end

  // Analog control accepts a write only when its lock bit is written as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_control_o <= REG_RST;
    end else if (wr_en && addr_i == ANALOG_CTL_OFS && !wdata_i[ANALOG_LOCK_BIT]) begin
      analog_control_o <= wdata_i & ANALOG_WMASK;
    end
  end

  // PWM duty assembled from both registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_duty_o <= 10'h000;
    end else if (ce_i) begin
      pwm_duty_o <= {pwm_data_reg, pwm_setup_o[PWM_LOW_MSB -: 2]};
    end
  end

  // Timer three gate follows the selected pin polarity
  assign t3_gate_ok = !timer_three_setup_o[T3_GATE_BIT] ||
                      (gate_sync == timer_three_setup_o[T3_POLARITY_BIT]);

  reload_timer #(
    .WIDTH   (8),
    .PS_BITS (3)
  ) u_timer_three (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .run_i      (timer_three_setup_o[T3_RUN_BIT]),
    .gate_ok_i  (t3_gate_ok),
    .prescale_i (timer_three_setup_o[T3_PS_MSB -: 3]),
    .load_i     (wr_i && addr_i == T3_COUNT_OFS),
    .reload_i   (t3_reload_reg),
    .count_o    (timer_three_count_o),
    .wrap_o     (t3_wrap)
  );

  // Pending interrupts: events set, written zeros clear, set wins
  always_comb begin
    events                 = event_i;
    events[IRQ_TIMER3_BIT] = event_i[IRQ_TIMER3_BIT] | t3_wrap;
    irq_next               = irq_reg;
    if (wr_i && addr_i == IRQ_PEND_OFS) begin
      irq_next = irq_reg & wdata_i;
    end
    irq_next = irq_next | events;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= REG_RST;
      irq_o   <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= irq_next;
      irq_o   <= |(irq_next & (wr_i && addr_i == IRQ_MASK_OFS ? wdata_i : imr_reg));
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    case (addr_i)
      P2_IN_OFS:        read_value = pin_sync;
      P2_OUT_OFS:       read_value = port_two_output_o;
      T3_COUNT_OFS:     read_value = timer_three_count_o;
      T3_RELOAD_OFS:    read_value = t3_reload_reg;
      PWM_DUTY_OFS:     read_value = pwm_data_reg;
      PWM_SETUP_OFS:    read_value = pwm_setup_o;
      CLOCK_EXT_OFS:    read_value = clock_extension_setup_o;
      SYSTEM_SETUP_OFS: read_value = system_setup_o;
      CMP_SETUP_OFS:    read_value = comparator_setup_o;
      CMP_REF_OFS:      read_value = comparator_reference_o;
      EXT_PAGE_OFS:     read_value = external_address_page_o;
      HELD_FLAGS_OFS:   read_value = held_flags_copy_o;
      AUDIO_WAKE_OFS: begin
        read_value                   = audio_wake_control_o;
        read_value[AWAKE_DETECT_BIT] = detect_sync;
      end
      ANALOG_CTL_OFS:   read_value = analog_control_o;
      IRQ_MASK_OFS:     read_value = imr_reg;
      IRQ_PEND_OFS:     read_value = irq_reg;
      default:          read_value = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? read_value : 8'h00;
    end
  end

  // Checks
  sequence seq_count_write;
    ce_i && wr_i && addr_i == T3_COUNT_OFS;
  endsequence

  sequence seq_reload_seen;
    timer_three_count_o == $past(t3_reload_reg);
  endsequence

  property p_count_reload;
    @(posedge clk_i) disable iff (!rst_n_i)
      seq_count_write |=> seq_reload_seen;
  endproperty

  a_count_write_reload: assert property (p_count_reload)
    else $error("count write did not load the reload value");

  a_irq_zero_clears: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_i && addr_i == IRQ_PEND_OFS
      |=> irq_reg == (($past(irq_reg) & $past(wdata_i)) | $past(events)))
    else $error("pending write did not follow zero-clears rule");

  a_irq_event_sets: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && t3_wrap |=> irq_reg[IRQ_TIMER3_BIT])
    else $error("timer three wrap did not set its pending bit");

  a_irq_output_level: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      irq_o == |(irq_reg & imr_reg))
    else $error("interrupt output disagrees with pending and mask");

  a_analog_locked: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_i && addr_i == ANALOG_CTL_OFS && wdata_i[ANALOG_LOCK_BIT]
      |=> $stable(analog_control_o))
    else $error("locked analog write changed the register");

  a_analog_open: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_i && addr_i == ANALOG_CTL_OFS && !wdata_i[ANALOG_LOCK_BIT]
      |=> analog_control_o == ($past(wdata_i) & ANALOG_WMASK))
    else $error("unlocked analog write not stored");

  a_read_one_cycle: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data present without a read");

  a_reserved_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && rd_i && addr_i == 8'hd0 |=> rdata_o == 8'h00)
    else $error("reserved address read nonzero");

  a_pwm_fixed_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      pwm_setup_o[4] == 1'b0 && pwm_setup_o[1] == 1'b0)
    else $error("pwm setup fixed-zero bit set");

  a_cmp_ref_upper: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_i && addr_i == CMP_REF_OFS
      |=> comparator_reference_o == {4'h0, $past(wdata_i[3:0])})
    else $error("comparator reference not stored as four bits");

  a_pin_two_stage: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i [*3] |-> pin_sync == $past(port_two_pin_i, 2))
    else $error("port two input not sampled through two stages");
endmodule // sfr_upper_bank
`default_nettype wire

// [test/core_master_model.sv]
// Core-side master model driving the register port
`timescale 1ns/1ps
`default_nettype none
module core_master_model
  import sfr_upper_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle write strobe, data inverted once released
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask

  // Data taken at the edge closing the answer cycle
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask

  // Held flags written with the trap bit clear
  task automatic flags_write(input logic [7:0] d);
    bus_write(HELD_FLAGS_OFS, d & 8'hef);
  endtask

  // Pending write keeping block and end-mark untouched
  task automatic pend_write(input logic [7:0] d);
    bus_write(IRQ_PEND_OFS, d | 8'h24);
  endtask

  // Read-modify-write that preserves the kept bits
  task automatic rmw(input logic [7:0] a, input logic [7:0] keep, input logic [7:0] d);
    logic [7:0] v;
    bus_read(a, v);
    bus_write(a, (v & keep) | (d & ~keep));
  endtask
endmodule // core_master_model
`default_nettype wire

// [test/test_sfr_upper_bank.sv]
// Self-checking bench for the upper register bank
`timescale 1ns/1ps
`default_nettype none
module test_sfr_upper_bank;
  import sfr_upper_pkg::*;
  logic       clk_i;
  logic       rst_n_i;
  logic       ce_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic [7:0] event_i;
  logic       irq_o;
  logic [7:0] pins;
  logic       cmp_a;
  logic       cmp_b;
  logic       wake;
  logic       gate;
  logic [7:0] p2_out;
  logic [7:0] t3_count;
  logic [7:0] t3_setup;
  logic [9:0] duty;
  logic [7:0] pwm_set;
  logic [7:0] an_ctl;
  logic [7:0] cmp_set, cmp_ref, ext_page, flags_cp, awake_ctl, clk_ext, sys_set, irq_mask;
  int         n_errors;
  int         tests_run;

  sfr_upper_bank DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .event_i(event_i), .irq_o(irq_o), .port_two_pin_i(pins),
    .comparator_a_output_i(cmp_a), .comparator_b_output_i(cmp_b),
    .wake_detect_i(wake), .timer_three_gate_pin_i(gate),
    .port_two_output_o(p2_out), .timer_three_count_o(t3_count),
    .timer_three_setup_o(t3_setup), .pwm_duty_o(duty), .pwm_setup_o(pwm_set),
    .comparator_setup_o(cmp_set), .comparator_reference_o(cmp_ref),
    .external_address_page_o(ext_page), .held_flags_copy_o(flags_cp),
    .audio_wake_control_o(awake_ctl), .clock_extension_setup_o(clk_ext),
    .system_setup_o(sys_set), .analog_control_o(an_ctl), .irq_mask_o(irq_mask)
  );

  core_master_model core (
    .clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    core.bus_read(a, d);
    check(d, exp);
  endtask

  // Reset values read over the port
  task automatic t_reset;
    logic [7:0] ra [14] = '{8'hce, 8'hcf, 8'hd2, 8'hd3, 8'hd5, 8'hd7, 8'hd8,
                            8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hef, 8'hfd, 8'hfe};
    for (int i = 0; i < 14; i++) begin
      rd_chk(ra[i], (ra[i] == 8'hd5) ? 8'hc0 : 8'h00);
    end
  endtask

  // Every event bit, clear by zero, one as no-op, masking
  task automatic t_irq;
    core.bus_write(IRQ_MASK_OFS, 8'hff);
    for (int i = 0; i < 8; i++) begin
      event_i <= 8'h01 << i;
      @(posedge clk_i);
      event_i <= 8'h00;
      rd_chk(IRQ_PEND_OFS, 8'(8'h01 << i));
      check(irq_o, 1'b1);
      core.bus_write(IRQ_PEND_OFS, 8'h00);
      rd_chk(IRQ_PEND_OFS, 8'h00);
    end
    event_i <= 8'hff;
    @(posedge clk_i);
    event_i <= 8'h00;
    core.pend_write(8'h00);
    rd_chk(IRQ_PEND_OFS, 8'h24);
    core.bus_write(IRQ_PEND_OFS, 8'hfb);
    rd_chk(IRQ_PEND_OFS, 8'h20);
    core.bus_write(IRQ_MASK_OFS, 8'hdf);
    check(irq_o, 1'b0);
    check(irq_mask, 8'hdf);
    core.bus_write(IRQ_PEND_OFS, 8'h00);
  endtask

  // Count load from reload, wrap event, write-only setup
  task automatic t_timer;
    int n;
    core.bus_write(T3_RELOAD_OFS, 8'hfe);
    rd_chk(T3_RELOAD_OFS, 8'hfe);
    core.bus_write(T3_COUNT_OFS, 8'h55);
    rd_chk(T3_COUNT_OFS, 8'hfe);
    check(t3_count, 8'hfe);
    core.bus_write(IRQ_MASK_OFS, 8'h10);
    core.bus_write(T3_SETUP_OFS, 8'h80);
    n = 0;
    while (irq_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) begin
      n_errors++;
      $display("unexpected at %0t: no timer wrap", $time);
      conclude();
    end
    core.bus_write(T3_SETUP_OFS, 8'hff);
    check(t3_setup, 8'hf7);
    rd_chk(T3_SETUP_OFS, 8'h00);
    // Gated at polarity high with the gate pin low: count must hold
    core.bus_write(T3_SETUP_OFS, 8'hd0);
    core.bus_write(T3_COUNT_OFS, 8'h00);
    rd_chk(T3_COUNT_OFS, 8'hfe);
    core.bus_write(T3_SETUP_OFS, 8'h00);
    core.bus_write(IRQ_PEND_OFS, 8'h00);
    check(irq_o, 1'b0);
  endtask

  // PWM duty split and setup fields
  task automatic t_pwm;
    core.bus_write(PWM_DUTY_OFS, 8'ha5);
    core.bus_write(PWM_SETUP_OFS, 8'hff);
    check(pwm_set, 8'hed);
    rd_chk(PWM_SETUP_OFS, 8'hed);
    rd_chk(PWM_DUTY_OFS, 8'ha5);
    check(duty, 10'h297);
  endtask

  // Analog lock, held flags, read-modify-write, reserved
  task automatic t_write_rules;
    core.bus_write(ANALOG_CTL_OFS, 8'hff);
    check(an_ctl, 8'h00);
    core.bus_write(ANALOG_CTL_OFS, 8'h7f);
    check(an_ctl, 8'h39);
    core.bus_write(ANALOG_CTL_OFS, 8'h80);
    rd_chk(ANALOG_CTL_OFS, 8'h39);
    core.flags_write(8'hff);
    check(flags_cp, 8'he1);
    rd_chk(HELD_FLAGS_OFS, 8'he1);
    core.bus_write(CLOCK_EXT_OFS, 8'h10);
    core.rmw(CLOCK_EXT_OFS, 8'h10, 8'h07);
    rd_chk(CLOCK_EXT_OFS, 8'h17);
    check(clk_ext, 8'h17);
    core.bus_write(EXT_PAGE_OFS, 8'hff);
    check(ext_page, 8'h3f);
    core.bus_write(SYSTEM_SETUP_OFS, 8'hff);
    check(sys_set, 8'hfb);
    core.bus_write(8'hd0, 8'hff);
    rd_chk(8'hd0, 8'h00);
    rd_chk(8'hd4, 8'h00);
  endtask

  // Port two, comparator and audio wake read paths
  task automatic t_pins;
    pins <= 8'h3c;
    cmp_a <= 1'b0;
    cmp_b <= 1'b0;
    core.bus_write(P2_OUT_OFS, 8'h5a);
    check(p2_out, 8'h5a);
    rd_chk(P2_OUT_OFS, 8'h5a);
    rd_chk(P2_IN_OFS, 8'h3c);
    core.bus_write(CMP_SETUP_OFS, 8'hff);
    rd_chk(CMP_SETUP_OFS, 8'h0f);
    cmp_a <= 1'b1;
    core.bus_write(CMP_REF_OFS, 8'hff);
    check(cmp_ref, 8'h0f);
    rd_chk(CMP_REF_OFS, 8'h0f);
    rd_chk(CMP_SETUP_OFS, 8'h8f);
    check(cmp_set, 8'h8f);
    core.bus_write(AUDIO_WAKE_OFS, 8'hff);
    check(awake_ctl, 8'hbf);
    rd_chk(AUDIO_WAKE_OFS, 8'hbf);
    wake <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(AUDIO_WAKE_OFS, 8'hff);
  endtask

  // Clock enable low: an event must not reach the pending register
  task automatic t_freeze;
    ce_i    <= 1'b0;
    event_i <= 8'h01;
    repeat (4) @(posedge clk_i);
    ce_i    <= 1'b1;
    event_i <= 8'h00;
    @(posedge clk_i);
    rd_chk(IRQ_PEND_OFS, 8'h00);
    check(irq_o, 1'b0);
  endtask

  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    event_i = 8'h00;
    pins = 8'h00;
    cmp_a = 1'b1;
    cmp_b = 1'b1;
    wake = 1'b0;
    gate = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_irq();
    t_timer();
    t_pwm();
    t_write_rules();
    t_pins();
    t_freeze();
    conclude();
  end
endmodule // test_sfr_upper_bank
`default_nettype wire
